// file: rtl/encoder_port_cfg.svh
/*
 * constants of the position port: register offsets, reset values,
 * mode codes and output timing counts.
 * assumes a 100 MHz hclk and a 32-bit ahb-lite register bus.
 */
//
// Contract
// (RULE1) output mode drives A, B and index, A and B a quarter period apart.
// (RULE2) A/B phase offset stays within ninety plus or minus twenty degrees.
// (RULE3) emulated output edges never exceed three megahertz output frequency.
// (RULE4) feedback position width for emulation is configurable up to 24 bits.
// (RULE5) pulses per revolution before quadrature multiplication are programmable.
// (RULE6) index position offset is programmable within one revolution and held.
// (RULE7) output pulses derive from changes of the cyclic absolute feedback position.
// (RULE8) up/down mode: up pulses raise, down pulses lower the commanded position.
// (RULE9) quadrature mode accepts A/B with index as command or feedback; the port uses it as command only.
// (RULE10) a slave follows a master's emulated output in speed and direction.
// (RULE11) port is one role at a time: step, up/down, quadrature in, or output.
// (RULE12) step/direction scaling of steps to motion is programmable.
// (RULE13) quadrature input counts every A and B edge by which channel leads.
// (RULE14) emulated index asserts once per revolution at the programmed offset.
`ifndef ENCODER_PORT_CFG_SVH
`define ENCODER_PORT_CFG_SVH

// ==========================================================
// register offsets
`define OFS_CTRL        8'h00
`define OFS_PPR         8'h04
`define OFS_IDX_OFS     8'h08
`define OFS_STEP_SCALE  8'h0c
`define OFS_CMD_POS     8'h10
`define OFS_EMU_CNT     8'h14
`define OFS_IDX_LATCH   8'h18

// ==========================================================
// mode codes and reset values
`define MODE_STEP_DIR   2'h0
`define MODE_UP_DOWN    2'h1
`define MODE_QUAD_IN    2'h2
`define MODE_QUAD_OUT   2'h3
`define RST_MODE        2'h0
`define RST_PPR         24'h000400
`define RST_IDX_OFS     26'h0000000
`define RST_STEP_SCALE  16'h0001

// ==========================================================
// output timing
`define CLK_KHZ         100000
`define MAX_OUT_KHZ     3000
`define EDGE_GAP        ((`CLK_KHZ + 4 * `MAX_OUT_KHZ - 1) / (4 * `MAX_OUT_KHZ))

`endif

// file: rtl/encoder_port_pkg.sv
/*
 * types of the position port: mode enumeration, pin groups and
 * the packed state record of the port.
 * assumes encoder_port_cfg.svh for the mode codes.
 */
`include "encoder_port_cfg.svh"

package encoder_port_pkg;

   typedef enum logic [1:0] {
      STEP_DIR = `MODE_STEP_DIR,
      UP_DOWN  = `MODE_UP_DOWN,
      QUAD_IN  = `MODE_QUAD_IN,
      QUAD_OUT = `MODE_QUAD_OUT
   } port_mode_t;

   // receiver side of the position_port_connector
   typedef struct packed {
      logic a;
      logic b;
      logic z;
   } pin_in_t;

   // driver side of the position_port_connector
   typedef struct packed {
      logic a;
      logic b;
      logic z;
      logic oe;
   } pin_out_t;

   typedef struct packed {
      port_mode_t   mode;
      logic [23:0]  ppr;
      logic [25:0]  idx_ofs;
      logic [15:0]  step_scale;
      logic [31:0]  cmd_pos;
      logic [31:0]  idx_latch;
      logic [25:0]  emu_cnt;
      logic [25:0]  tgt;
      logic [3:0]   gap;
      pin_in_t      pin_prev;
      pin_out_t     pout;
      logic         a_valid;
      logic         a_write;
      logic [7:0]   a_addr;
      logic [31:0]  rdata;
   } port_state_t;

endpackage

// file: rtl/encoder_port.sv
/*
 * position port of a motor drive: step/direction, up/down and
 * quadrature inputs drive a commanded position; quadrature output
 * mode emulates an encoder from the absolute feedback position.
 * assumes pins already synchronous to hclk and an ahb-lite master
 * that issues single word transfers.
 */
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "encoder_port_cfg.svh"

module encoder_port #(
   parameter int RES_W = 24
) (
   // clock and reset
   input  wire logic                      hclk,
   input  wire logic                      hresetn,
   // ahb-lite slave
   input  wire logic                      hsel,
   input  wire logic [31:0]               haddr,
   input  wire logic [1:0]                htrans,
   input  wire logic                      hwrite,
   input  wire logic [2:0]                hsize,
   input  wire logic [31:0]               hwdata,
   input  wire logic                      hready,
   output logic                           hreadyout,
   output logic                           hresp,
   output logic [31:0]                    hrdata,
   // primary feedback, cyclic absolute position within one turn
   input  wire logic [RES_W-1:0]          fb_position,
   // position_port_connector
   input  wire encoder_port_pkg::pin_in_t  pin_in,
   output encoder_port_pkg::pin_out_t      pin_out,
   // commanded position to the motion loop
   output logic [31:0]                    cmd_position
);
   import encoder_port_pkg::*;

   localparam logic [3:0] GAP_RELOAD = 4'(`EDGE_GAP - 1);

   if (RES_W < 1 || RES_W > 24) begin : g_chk
      $error("RES_W must lie between 1 and 24");
   end
   if (`EDGE_GAP < 1 || `EDGE_GAP > 16) begin : g_gap
      $error("edge gap does not fit its counter");
   end

   port_state_t st_r;
   port_state_t st_nxt;

   // ==========================================================
   // helpers

   // +1 / -1 / 0 from one quadrature sample pair, every edge counts
   function automatic logic [1:0] quad_step(input logic [1:0] p, input logic [1:0] c);
      logic [3:0] t;
      t = {p, c};
      case (t)
         4'b0010, 4'b1011, 4'b1101, 4'b0100: quad_step = 2'b01;
         4'b0001, 4'b0111, 4'b1110, 4'b1000: quad_step = 2'b11;
         default:                            quad_step = 2'b00;
      endcase
   endfunction

   // one count forward or back inside a revolution of span counts
   function automatic logic [25:0] wrap_step(input logic [25:0] v, input logic up,
                                             input logic [25:0] span);
      if (up) begin
         wrap_step = (v == span - 26'h1) ? 26'h0 : v + 26'h1;
      end else begin
         wrap_step = (v == 26'h0) ? span - 26'h1 : v - 26'h1;
      end
   endfunction

   // quadrature phase of a count: 00, 10, 11, 01 as {a, b}
   function automatic logic [1:0] quad_phase(input logic [1:0] c);
      quad_phase = {c[1] ^ c[0], c[1]};
   endfunction

   function automatic logic [31:0] read_reg(input port_state_t s, input logic [7:0] a);
      read_reg = 32'h0;
      if (a == `OFS_CTRL) begin
         read_reg = {30'h0, s.mode};
      end else if (a == `OFS_PPR) begin
         read_reg = {8'h0, s.ppr};
      end else if (a == `OFS_IDX_OFS) begin
         read_reg = {6'h0, s.idx_ofs};
      end else if (a == `OFS_STEP_SCALE) begin
         read_reg = {16'h0, s.step_scale};
      end else if (a == `OFS_CMD_POS) begin
         read_reg = s.cmd_pos;
      end else if (a == `OFS_EMU_CNT) begin
         read_reg = {6'h0, s.emu_cnt};
      end else if (a == `OFS_IDX_LATCH) begin
         read_reg = s.idx_latch;
      end
   endfunction

   // ==========================================================
   // combinational part
   logic [25:0] span;
   logic [49:0] prod;
   logic [25:0] delta;
   logic [1:0]  qstep;
   logic [1:0]  ph;
   logic        take;
   logic [31:0] scale32;

   always_comb begin
      st_nxt  = st_r;
      span    = {st_r.ppr, 2'b00};
      // widen both factors first so the product keeps its upper bits
      prod    = 50'({{(26 - RES_W){1'b0}}, fb_position}) * 50'(span);
      delta   = 26'h0;
      qstep   = 2'b00;
      ph      = 2'b00;
      scale32 = {16'h0, st_r.step_scale};
      take    = hsel & hready & htrans[1];

      // bus: address phase captured, write applied in data phase
      st_nxt.rdata = 32'h0;
      if (hready) begin
         st_nxt.a_valid = take;
         st_nxt.a_write = take & hwrite;
         st_nxt.a_addr  = haddr[7:0];
         if (take && !hwrite) begin
            st_nxt.rdata = read_reg(st_r, haddr[7:0]);
         end
      end
      if (st_r.a_valid && st_r.a_write) begin
         if (st_r.a_addr == `OFS_CTRL) begin
            st_nxt.mode = port_mode_t'(hwdata[1:0]);                       // see (RULE11)
         end else if (st_r.a_addr == `OFS_PPR) begin
            st_nxt.ppr = (hwdata[23:0] == 24'h0) ? 24'h1 : hwdata[23:0];    // see (RULE5)
         end else if (st_r.a_addr == `OFS_IDX_OFS) begin
            st_nxt.idx_ofs = hwdata[25:0];                                  // see (RULE6)
         end else if (st_r.a_addr == `OFS_STEP_SCALE) begin
            st_nxt.step_scale = hwdata[15:0];                               // see (RULE12)
         end else if (st_r.a_addr == `OFS_CMD_POS) begin
            st_nxt.cmd_pos = hwdata;
         end
      end

      // emulation target: feedback scaled to counts per turn
      st_nxt.tgt = 26'(prod >> RES_W);                                      // see (RULE4)
      st_nxt.pin_prev = pin_in;

      case (st_r.mode)
         STEP_DIR: begin
            if (pin_in.a && !st_r.pin_prev.a) begin
               st_nxt.cmd_pos = pin_in.b ? st_r.cmd_pos - scale32
                                         : st_r.cmd_pos + scale32;          // see (RULE12)
            end
         end
         UP_DOWN: begin
            if (pin_in.a && !st_r.pin_prev.a && !(pin_in.b && !st_r.pin_prev.b)) begin
               st_nxt.cmd_pos = st_r.cmd_pos + scale32;                     // see (RULE8)
            end else if (pin_in.b && !st_r.pin_prev.b && !(pin_in.a && !st_r.pin_prev.a)) begin
               st_nxt.cmd_pos = st_r.cmd_pos - scale32;                     // see (RULE8)
            end
         end
         QUAD_IN: begin
            qstep = quad_step({st_r.pin_prev.a, st_r.pin_prev.b}, {pin_in.a, pin_in.b});
            if (qstep == 2'b01) begin
               st_nxt.cmd_pos = st_r.cmd_pos + 32'h1;                       // see (RULE13)
            end else if (qstep == 2'b11) begin
               st_nxt.cmd_pos = st_r.cmd_pos - 32'h1;                       // see (RULE10)
            end
            if (pin_in.z && !st_r.pin_prev.z) begin
               st_nxt.idx_latch = st_nxt.cmd_pos;                           // see (RULE9)
            end
         end
         default: begin
         end
      endcase

      // emulated encoder: walk one count per allowed edge toward target
      if (st_r.mode == QUAD_OUT) begin
         if (st_r.gap != 4'h0) begin
            st_nxt.gap = st_r.gap - 4'h1;                                   // see (RULE3)
         end else if (st_r.tgt != st_r.emu_cnt) begin
            delta = (st_r.tgt >= st_r.emu_cnt) ? st_r.tgt - st_r.emu_cnt
                                               : st_r.tgt + span - st_r.emu_cnt;
            // shortest way round the turn decides direction
            st_nxt.emu_cnt = wrap_step(st_r.emu_cnt, delta <= (span >> 1), span);   // see (RULE7)
            st_nxt.gap     = GAP_RELOAD;                                    // see (RULE2)
         end
      end else begin
         // silent tracking so entering output mode gives no burst
         st_nxt.emu_cnt = (st_r.tgt >= span) ? 26'h0 : st_r.tgt;
         st_nxt.gap     = 4'h0;
      end

      ph = quad_phase(st_nxt.emu_cnt[1:0]);
      st_nxt.pout.oe = (st_r.mode == QUAD_OUT);                              // see (RULE11)
      // outputs stay low while the port is not driving
      st_nxt.pout.a  = (st_r.mode == QUAD_OUT) & ph[1];                      // see (RULE1)
      st_nxt.pout.b  = (st_r.mode == QUAD_OUT) & ph[0];
      st_nxt.pout.z  = (st_r.mode == QUAD_OUT) && (st_nxt.emu_cnt == st_r.idx_ofs); // see (RULE14)
   end

   // ==========================================================
   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r            <= '0;
         st_r.mode       <= port_mode_t'(`RST_MODE);
         st_r.ppr        <= `RST_PPR;
         st_r.idx_ofs    <= `RST_IDX_OFS;
         st_r.step_scale <= `RST_STEP_SCALE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // outputs
   assign hreadyout    = 1'b1;
   assign hresp        = 1'b0;
   assign hrdata       = st_r.rdata;
   assign pin_out      = st_r.pout;
   assign cmd_position = st_r.cmd_pos;

endmodule
`default_nettype wire

// file: tb/encoder_port_props.sv
/* checker of the position port outputs.
   bound to every encoder_port instance; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module encoder_port_props (
   // bus
   input wire logic                       hclk,
   input wire logic                       hresetn,
   input wire logic                       hsel,
   input wire logic [1:0]                 htrans,
   input wire logic                       hwrite,
   input wire logic                       hready,
   input wire logic                       hreadyout,
   input wire logic                       hresp,
   input wire logic [31:0]                hrdata,
   // pins and command
   input wire encoder_port_pkg::pin_in_t  pin_in,
   input wire encoder_port_pkg::pin_out_t pin_out,
   input wire logic [31:0]                cmd_position
);
   import encoder_port_pkg::*;
   logic       wdp_r, rdp_r, oe_r, chg_r;
   logic [1:0] ab_r, wsh_r;
   logic [2:0] psh_r;
   logic [3:0] gap_r;
   pin_in_t    pprev_r;
   // ==========================================
   // history of bus phases, pin edges and output steps
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {wdp_r, rdp_r, oe_r, chg_r, ab_r, wsh_r, psh_r, pprev_r} <= '0;
         gap_r <= 4'hf;
      end else begin
         wdp_r <= hsel & hready & htrans[1] & hwrite;
         rdp_r <= hsel & hready & htrans[1] & ~hwrite;
         wsh_r <= {wsh_r[0], wdp_r};
         oe_r <= pin_out.oe;
         pprev_r <= pin_in;
         psh_r <= {psh_r[1:0], pin_in != pprev_r};
         ab_r <= {pin_out.a, pin_out.b};
         chg_r <= oe_r & pin_out.oe & ({pin_out.a, pin_out.b} != ab_r);
         if (oe_r & pin_out.oe & ({pin_out.a, pin_out.b} != ab_r)) gap_r <= 4'h0;
         else if (gap_r != 4'hf) gap_r <= gap_r + 4'h1;
      end
   end
   // ==========================================
   // assertions
   AST_BUS_OKAY: assert property (@(posedge hclk) disable iff (!hresetn)
      hreadyout && !hresp) else $error("bus answer not ready and okay");
   AST_RDATA_IDLE: assert property (@(posedge hclk) disable iff (!hresetn)
      !rdp_r |-> hrdata == 32'h0) else $error("read data outside data phase");
   AST_QUAD_STEP: assert property (@(posedge hclk) disable iff (!hresetn)
      (oe_r && pin_out.oe) |-> (({pin_out.a, pin_out.b} ^ ab_r) != 2'h3))
      else $error("a and b changed together");
   AST_EDGE_GAP: assert property (@(posedge hclk) disable iff (!hresetn)
      (oe_r && pin_out.oe && {pin_out.a, pin_out.b} != ab_r) |-> gap_r >= 4'h8)
      else $error("output edges closer than nine cycles");
   AST_OE_QUIET: assert property (@(posedge hclk) disable iff (!hresetn)
      !pin_out.oe |-> !pin_out.a && !pin_out.b && !pin_out.z)
      else $error("outputs active while not driving");
   AST_OE_CAUSE: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(pin_out.oe) |-> $past(wdp_r) || $past(wdp_r, 2) || $past(wdp_r, 3))
      else $error("output enable rose without a write");
   AST_CMD_CAUSE: assert property (@(posedge hclk) disable iff (!hresetn)
      $changed(cmd_position) |-> (|psh_r) || (|wsh_r))
      else $error("command moved without pin edge or write");
   AST_INDEX_CAUSE: assert property (@(posedge hclk) disable iff (!hresetn)
      ($rose(pin_out.z) && oe_r) |-> chg_r || ({pin_out.a, pin_out.b} != ab_r) || (|wsh_r))
      else $error("index rose without an output step");
   COV_OE: cover property (@(posedge hclk) disable iff (!hresetn) $rose(pin_out.oe));
   COV_Z: cover property (@(posedge hclk) disable iff (!hresetn) $rose(pin_out.z));
   COV_CMD: cover property (@(posedge hclk) disable iff (!hresetn) $changed(cmd_position));
endmodule
bind encoder_port encoder_port_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .pin_in(pin_in), .pin_out(pin_out), .cmd_position(cmd_position));
`default_nettype wire

// file: tb/pin_partner.sv
/* far side of the position port: a controller sending step, up/down
   or quadrature events and a slave counting the emulated output.
   assumes one go pulse per event, kind and dn held meanwhile. */
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
   // clock and reset
   input wire logic                       hclk,
   input wire logic                       hresetn,
   // event request
   input wire logic [1:0]                 kind,
   input wire logic                       go,
   input wire logic                       dn,
   // connector
   input wire encoder_port_pkg::pin_out_t pin_out,
   output encoder_port_pkg::pin_in_t      pin,
   // count decoded from the emulated output
   output logic [31:0]                    rx_cnt
);
   import encoder_port_pkg::*;
   logic [1:0] ph, q, nq, rq, rq_p;
   assign nq = dn ? q - 2'h1 : q + 2'h1;
   assign rq = {pin_out.b, pin_out.a ^ pin_out.b};
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {pin, ph, q, rq_p, rx_cnt} <= '0;
      end else begin
         rq_p <= rq;
         if (pin_out.oe && rq == rq_p + 2'h1) rx_cnt <= rx_cnt + 32'h1;
         else if (pin_out.oe && rq == rq_p - 2'h1) rx_cnt <= rx_cnt - 32'h1;
         if (go && kind == 2'h2) begin
            q <= nq;
            pin.a <= nq[1] ^ nq[0];
            pin.b <= nq[1];
         end else if (go && kind == 2'h3) begin
            pin.z <= ~pin.z;
         end else if (go) begin
            ph <= 2'h1;
            pin.b <= (kind == 2'h0) & dn;
         end else if (ph == 2'h1) begin
            ph <= 2'h2;
            if (kind == 2'h1 && dn) pin.b <= 1'b1;
            else pin.a <= 1'b1;
         end else if (ph != 2'h0) begin
            ph <= ph + 2'h1;
            pin.a <= 1'b0;
            pin.b <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// file: tb/encoder_port_tb.sv
/* self-checking bench of the position port: bus tasks, one task per
   scenario and the closing report. assumes pin_partner on the pins. */
`timescale 1ns/1ps
`default_nettype none
`include "encoder_port_cfg.svh"
module encoder_port_tb;
   import encoder_port_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hready, hresp, go, dn, z_q;
   logic [1:0]  htrans, kind;
   logic [23:0] fb_position;
   logic [31:0] haddr, hwdata, hrdata, cmd_position, rx_cnt, rd, r0;
   pin_in_t     pin_in;
   pin_out_t    pin_out;
   int          n_mismatch, tests_run, cyc, z_rises;
   encoder_port #(.RES_W(24)) DUT (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
      .hresp(hresp), .hrdata(hrdata), .fb_position(fb_position), .pin_in(pin_in),
      .pin_out(pin_out), .cmd_position(cmd_position));
   pin_partner PEER (.hclk(hclk), .hresetn(hresetn), .kind(kind), .go(go), .dn(dn),
      .pin_out(pin_out), .pin(pin_in), .rx_cnt(rx_cnt));
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   // ==========================================
   // index edge count and timeout
   always @(posedge hclk) begin
      cyc = cyc + 1;
      if (pin_out.z === 1'b1 && z_q === 1'b0) z_rises = z_rises + 1;
      z_q = pin_out.z;
      if (cyc == 20000) begin
         n_mismatch = n_mismatch + 1;
         complete_run;
      end
   end
   // ==========================================
   // bus and event tasks
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run = tests_run + 1;
      if (got !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(nm, exp, rd);
   endtask
   task automatic ev(input logic [1:0] k, input logic d, input int n);
      repeat (n) begin
         @(posedge hclk);
         kind <= k;
         dn <= d;
         go <= 1'b1;
         @(posedge hclk);
         go <= 1'b0;
         repeat (4) @(posedge hclk);
      end
   endtask
   task automatic wait_emu(input logic [31:0] t);
      rd = 'x;
      for (int i = 0; i < 40 && rd !== t; i++) bus(1'b0, `OFS_EMU_CNT, 32'h0);
      chk("emu_cnt", t, rd);
   endtask
   // ==========================================
   // scenarios
   task automatic t_regs;
      rdchk("ctrl", `OFS_CTRL, 32'h0);
      rdchk("ppr", `OFS_PPR, 32'h400);
      rdchk("idx_ofs", `OFS_IDX_OFS, 32'h0);
      rdchk("scale", `OFS_STEP_SCALE, 32'h1);
      rdchk("unmapped", 8'h1c, 32'h0);
      bus(1'b1, `OFS_PPR, 32'h0);
      rdchk("ppr_zero", `OFS_PPR, 32'h1);
      bus(1'b1, `OFS_EMU_CNT, 32'h55);
      rdchk("emu_ro", `OFS_EMU_CNT, 32'h0);
      $display("t_regs done");
   endtask
   task automatic t_inputs;
      bus(1'b1, `OFS_STEP_SCALE, 32'h3);
      ev(2'h0, 1'b0, 2);
      ev(2'h0, 1'b1, 1);
      chk("step_cmd", 32'h3, cmd_position);
      bus(1'b1, `OFS_CTRL, 32'h1);
      ev(2'h1, 1'b0, 3);
      ev(2'h1, 1'b1, 1);
      rdchk("updown_cmd", `OFS_CMD_POS, 32'h9);
      bus(1'b1, `OFS_CTRL, 32'h2);
      ev(2'h2, 1'b0, 5);
      ev(2'h2, 1'b1, 2);
      chk("quad_cmd", 32'hc, cmd_position);
      ev(2'h3, 1'b0, 2);
      rdchk("idx_latch", `OFS_IDX_LATCH, 32'hc);
      $display("t_inputs done");
   endtask
   task automatic t_output;
      bus(1'b1, `OFS_PPR, 32'h4);
      bus(1'b1, `OFS_IDX_OFS, 32'h3);
      rdchk("idx_set", `OFS_IDX_OFS, 32'h3);
      bus(1'b1, `OFS_CTRL, 32'h3);
      r0 = rx_cnt;
      fb_position <= 24'h500000;
      wait_emu(32'h5);
      chk("rx_up", r0 + 32'h5, rx_cnt);
      chk("z_up", 32'h1, z_rises);
      ev(2'h2, 1'b0, 2);
      chk("cmd_hold", 32'hc, cmd_position);
      fb_position <= 24'h200000;
      wait_emu(32'h2);
      chk("rx_down", r0 + 32'h2, rx_cnt);
      chk("z_down", 32'h2, z_rises);
      $display("t_output done");
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      {hsel, hwrite, go, dn, kind, htrans, z_q} = '0;
      {haddr, hwdata, fb_position} = '0;
      {n_mismatch, tests_run, cyc, z_rises} = '0;
      hresetn = 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs;
      t_inputs;
      t_output;
      complete_run;
   end
endmodule
`default_nettype wire
